// ===== hw/cadc_defines.vh
// Constants for the charge converter tracking, filter and serial output
// How it works
// - Tracking steps DAC code at 2 MHz.
// - Integration period length is user chosen.
// - Filter takes start and end data points.
// - Result is end point minus start point.
// - User sets oversample count per point.
// - Each result is 20 bits wide.
// - Serial shifting runs independent of conversion.
// - Serial outputs chain in series; output enable stays low after the first load.
// - Test pin enables internal test current.
`ifndef CADC_DEFINES_VH
`define CADC_DEFINES_VH
`define CADC_SYS_CLK_HZ    40000000
`define CADC_TRACK_HZ      2000000
`define CADC_TRACK_DIV     (`CADC_SYS_CLK_HZ / `CADC_TRACK_HZ)
`define CADC_RES_W         20
`define CADC_DAC_W         16
`define CADC_ACC_W         24
`define CADC_FIFO_DEPTH    4
`define CADC_ST_IDLE       2'h0
`define CADC_ST_START      2'h1
`define CADC_ST_INTEG      2'h2
`define CADC_ST_END        2'h3
`endif

// ===== hw/cadc_top.v
// Tracking logic, double-sampling filter, result FIFO and serial output
`timescale 1ns/1ps
`include "cadc_defines.vh"

module cadc_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             i_sys_clk, // Clock
	input  wire             i_srst,    // Sync reset
	input  wire             i_in_vld,  // Write valid
	output wire             o_in_rdy,  // Not full
	input  wire [WIDTH-1:0] i_in_dat,  // Write data
	output wire             o_out_vld, // Not empty
	input  wire             i_out_rdy, // Read ready
	output wire [WIDTH-1:0] o_out_dat  // Head data
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      cnt_ff;
	wire            push;
	wire            pop;

	assign o_in_rdy  = (cnt_ff != DEPTH[AW:0]);
	assign o_out_vld = (cnt_ff != {(AW+1){1'b0}});
	assign o_out_dat = mem_ff[rd_ptr_ff];
	assign push      = i_in_vld & o_in_rdy;
	assign pop       = o_out_vld & i_out_rdy;

	// Pointers wrap, depth assumed a power of two
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			cnt_ff    <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_ff[wr_ptr_ff] <= i_in_dat;
				wr_ptr_ff         <= wr_ptr_ff + 1'b1;
			end
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push & ~pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop & ~push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // cadc_fifo

module cadc_top #(
	parameter DAC_W = `CADC_DAC_W,
	parameter RES_W = `CADC_RES_W,
	parameter ACC_W = `CADC_ACC_W
) (
	input  wire             i_sys_clk,      // 40 MHz clock
	input  wire             i_srst,         // Sync reset, active high
	input  wire             i_cmp,          // Comparator: node above ground
	input  wire             i_conv_start,   // Pin: begin integration
	input  wire             i_conv_end,     // Pin: end integration
	input  wire [7:0]       i_os_count,     // Oversamples per point, 0 means 1
	input  wire             i_test_en,      // Pin: test current request
	input  wire             i_sclk,         // Serial shift clock pin
	input  wire             i_sload,        // Serial load pin
	input  wire             i_sdin,         // Chain input from next unit
	output reg  [DAC_W-1:0] o_dac_code,     // Capacitor array DAC code
	output reg              o_test_src_on,  // Test current source switch
	output reg              o_sdout,        // Serial data out
	output reg              o_sdout_oe_n,   // Output enable, low drives
	output reg              o_busy          // Conversion in progress
);
	// Pin synchronisers, first stage read only by second
	reg [6:0] s1_ff;
	reg [6:0] s2_ff;
	reg       sclk_d_ff;
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			s1_ff     <= 7'h00;
			s2_ff     <= 7'h00;
			sclk_d_ff <= 1'b0;
		end else begin
			s1_ff     <= {i_sdin, i_cmp, i_conv_start, i_conv_end, i_test_en, i_sclk, i_sload};
			s2_ff     <= s1_ff;
			sclk_d_ff <= s2_ff[1];
		end
	end
	wire sdin_s  = s2_ff[6]; // Chain pin comes from another unit
	wire cmp_s   = s2_ff[5];
	wire start_s = s2_ff[4];
	wire end_s   = s2_ff[3];
	wire test_s  = s2_ff[2];
	wire sclk_s  = s2_ff[1];
	wire sload_s = s2_ff[0];
	wire sclk_rise = sclk_s & ~sclk_d_ff;

	// Test current follows its pin
	always @(posedge i_sys_clk) begin
		if (i_srst)
			o_test_src_on <= 1'b0;
		else
			o_test_src_on <= test_s;
	end

	// Tracking rate divider, one-cycle enable
	reg [7:0]  div_ff;
	wire       trk_en     = (div_ff == 8'h00);
	wire [31:0] trk_reload = `CADC_TRACK_DIV - 1; // Cut to counter width below
	always @(posedge i_sys_clk) begin
		if (i_srst)
			div_ff <= 8'h00;
		else if (trk_en)
			div_ff <= trk_reload[7:0];
		else
			div_ff <= div_ff - 8'h01;
	end

	// Step the DAC code toward the node's virtual ground, saturating
	always @(posedge i_sys_clk) begin
		if (i_srst)
			o_dac_code <= {DAC_W{1'b0}};
		else if (trk_en) begin
			if (cmp_s && o_dac_code != {DAC_W{1'b1}})
				o_dac_code <= o_dac_code + 1'b1;
			else if (!cmp_s && o_dac_code != {DAC_W{1'b0}})
				o_dac_code <= o_dac_code - 1'b1;
		end
	end

	// Sequencer: start point, integration, end point
	reg [1:0]       st_ff;
	reg [1:0]       nxt_st;
	reg [7:0]       os_cnt_ff;
	reg [ACC_W-1:0] acc_ff;
	reg [ACC_W-1:0] start_pt_ff;
	reg             res_vld_ff;
	reg [RES_W-1:0] res_ff;
	wire [7:0]      os_last = (i_os_count == 8'h00) ? 8'h00 : i_os_count - 8'h01;
	wire            os_done = trk_en && (os_cnt_ff == os_last);
	wire            fifo_in_rdy;
	wire [ACC_W-1:0] acc_nxt = acc_ff + {{(ACC_W-DAC_W){1'b0}}, o_dac_code};
	wire [ACC_W-1:0] diff    = acc_nxt - start_pt_ff;

	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			`CADC_ST_IDLE:  if (start_s) nxt_st = `CADC_ST_START;
			`CADC_ST_START: if (os_done) nxt_st = `CADC_ST_INTEG;
			`CADC_ST_INTEG: if (end_s && fifo_in_rdy) nxt_st = `CADC_ST_END;
			`CADC_ST_END:   if (os_done) nxt_st = `CADC_ST_IDLE;
			default:        nxt_st = `CADC_ST_IDLE;
		endcase
	end

	// Accumulate the programmed number of oversamples per point
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_ff       <= `CADC_ST_IDLE;
			os_cnt_ff   <= 8'h00;
			acc_ff      <= {ACC_W{1'b0}};
			start_pt_ff <= {ACC_W{1'b0}};
			res_vld_ff  <= 1'b0;
			res_ff      <= {RES_W{1'b0}};
			o_busy      <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			res_vld_ff <= 1'b0;
			o_busy     <= (nxt_st != `CADC_ST_IDLE);
			if ((st_ff == `CADC_ST_START || st_ff == `CADC_ST_END) && trk_en) begin
				if (os_done) begin
					os_cnt_ff <= 8'h00;
					acc_ff    <= {ACC_W{1'b0}};
					if (st_ff == `CADC_ST_START)
						start_pt_ff <= acc_nxt;
					else begin
						res_ff     <= diff[RES_W-1:0];
						res_vld_ff <= 1'b1;
					end
				end else begin
					os_cnt_ff <= os_cnt_ff + 8'h01;
					acc_ff    <= acc_nxt;
				end
			end
		end
	end

	// Buffer decouples conversion from serial timing
	wire             fifo_vld;
	wire [RES_W-1:0] fifo_dat;
	wire             fifo_pop;
	cadc_fifo #(
		.WIDTH (RES_W),
		.DEPTH (`CADC_FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_in_vld  (res_vld_ff),
		.o_in_rdy  (fifo_in_rdy),
		.i_in_dat  (res_ff),
		.o_out_vld (fifo_vld),
		.i_out_rdy (fifo_pop),
		.o_out_dat (fifo_dat)
	);

	// Serial register: load on sload, shift on rising sclk edges
	reg [RES_W-1:0] hold_ff;
	reg [RES_W-1:0] shreg_ff;
	assign fifo_pop = fifo_vld; // Hold register always takes the newest
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			hold_ff      <= {RES_W{1'b0}};
			shreg_ff     <= {RES_W{1'b0}};
			o_sdout      <= 1'b0;
			o_sdout_oe_n <= 1'b1;
		end else begin
			if (fifo_vld)
				hold_ff <= fifo_dat;
			if (sload_s) begin
				shreg_ff     <= hold_ff;
				o_sdout      <= hold_ff[RES_W-1];
				o_sdout_oe_n <= 1'b0;
			end else if (sclk_rise) begin
				shreg_ff <= {shreg_ff[RES_W-2:0], sdin_s};
				o_sdout  <= shreg_ff[RES_W-2];
			end
		end
	end
endmodule // cadc_top

// ===== dv/cadc_asserts.sv
// Port checker for the converter block
`timescale 1ns/1ps
module cadc_asserts #(parameter DAC_W = 16) (
	input wire             i_sys_clk,     // Clock
	input wire             i_srst,        // Reset
	input wire             i_cmp,         // Comparator
	input wire             i_conv_start,  // Start pin
	input wire             i_test_en,     // Test pin
	input wire             i_sclk,        // Shift clock
	input wire             i_sload,       // Load pin
	input wire [DAC_W-1:0] o_dac_code,    // DAC code
	input wire             o_test_src_on, // Test source
	input wire             o_sdout,       // Serial data
	input wire             o_sdout_oe_n,  // Enable, low drives
	input wire             o_busy         // Busy
);
	reg [4:0] gap_ff;
	reg [4:0] act_ff;
	reg [2:0] rst_ff;
	// Gap saturates at reset so the first DAC move is free
	always @(posedge i_sys_clk) begin
		act_ff <= {act_ff[3:0], i_sclk | i_sload};
		rst_ff <= {rst_ff[1:0], i_srst};
		if (i_srst) gap_ff <= 5'h1f;
		else if (o_dac_code != $past(o_dac_code)) gap_ff <= 5'h00;
		else if (gap_ff != 5'h1f) gap_ff <= gap_ff + 5'h01;
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	property p_test; rst_ff == 3'h0 |-> o_test_src_on == $past(i_test_en, 3); endproperty
	a_test: assert property (p_test) else $error("test source lag");
	property p_rate; $changed(o_dac_code) |-> gap_ff >= 5'h13; endproperty
	a_rate: assert property (p_rate) else $error("DAC step too soon");
	property p_up; i_cmp [*5] ##0 $changed(o_dac_code) |-> o_dac_code > $past(o_dac_code); endproperty
	a_up: assert property (p_up) else $error("DAC stepped wrong way");
	property p_hold; $changed(o_sdout) |-> act_ff != 5'h00; endproperty
	a_hold: assert property (p_hold) else $error("serial data moved alone");
	property p_oe; !o_sdout_oe_n |=> !o_sdout_oe_n; endproperty
	a_oe: assert property (p_oe) else $error("output released");
	property p_load; $rose(i_sload) |-> ##[1:5] !o_sdout_oe_n; endproperty
	a_load: assert property (p_load) else $error("load not driving");
	property p_start; $rose(o_busy) |-> $past(i_conv_start, 2) || $past(i_conv_start, 3); endproperty
	a_start: assert property (p_start) else $error("busy without start");
	property p_len; $rose(o_busy) |=> o_busy [*8]; endproperty
	a_len: assert property (p_len) else $error("start point cut short");
endmodule // cadc_asserts
bind cadc_top cadc_asserts #(.DAC_W(DAC_W)) u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cmp(i_cmp),
	.i_conv_start(i_conv_start), .i_test_en(i_test_en), .i_sclk(i_sclk), .i_sload(i_sload), .o_dac_code(o_dac_code),
	.o_test_src_on(o_test_src_on), .o_sdout(o_sdout), .o_sdout_oe_n(o_sdout_oe_n), .o_busy(o_busy));

// ===== dv/cadc_host_model.sv
// Host that loads and clocks out one result
`timescale 1ns/1ps
module cadc_host_model #(parameter HALF = 4) (
	input  wire        i_sys_clk, // Clock
	input  wire        i_req,     // Read request
	input  wire        i_sdout,   // Serial data
	output reg         o_sload,   // Load pin
	output reg         o_sclk,    // Shift clock
	output reg  [19:0] o_word,    // Word read
	output reg         o_done     // Word ready
);
	integer i;
	// Shift clock stands low between reads; HALF covers the pin lag
	initial begin
		o_sload = 1'b0;
		o_sclk = 1'b0;
		o_word = 20'h0;
		o_done = 1'b0;
		forever begin
			@(posedge i_sys_clk);
			if (i_req) begin
				o_done <= 1'b0;
				o_sload <= 1'b1;
				repeat (HALF) @(posedge i_sys_clk);
				o_sload <= 1'b0;
				for (i = 0; i < 20; i = i + 1) begin
					repeat (HALF) @(posedge i_sys_clk);
					o_word <= {o_word[18:0], i_sdout};
					o_sclk <= 1'b1;
					repeat (HALF) @(posedge i_sys_clk);
					o_sclk <= 1'b0;
				end
				o_done <= 1'b1;
			end
		end
	end
endmodule // cadc_host_model

// ===== dv/tb.sv
// Bench: conversions, serial reads, test pin
`timescale 1ns/1ps
module tb;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         cmp = 1'b0;
	reg         cs = 1'b0;
	reg         ce = 1'b0;
	reg         ten = 1'b0;
	reg         sdi = 1'b1;
	reg         req = 1'b0;
	reg  [7:0]  osn = 8'h01;
	reg  [19:0] r1, r2;
	wire [19:0] word;
	wire [15:0] dac;
	wire        sclk, sload, sdout, oe_n, busy, tsrc, done;
	integer     err_total = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	cadc_top uut (.i_sys_clk(clk), .i_srst(rst), .i_cmp(cmp), .i_conv_start(cs), .i_conv_end(ce), .i_os_count(osn),
		.i_test_en(ten), .i_sclk(sclk), .i_sload(sload), .i_sdin(sdi), .o_dac_code(dac), .o_test_src_on(tsrc),
		.o_sdout(sdout), .o_sdout_oe_n(oe_n), .o_busy(busy));
	cadc_host_model host (.i_sys_clk(clk), .i_req(req), .i_sdout(sdout), .o_sload(sload), .o_sclk(sclk),
		.o_word(word), .o_done(done));
	// 40 MHz clock
	initial forever #12.5 clk = ~clk;
	// Hang guard, well above the few thousand cycles needed
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			give_verdict;
		end
	end
	task chk(input ok, input [8*8-1:0] msg);
		begin
			cmp_count = cmp_count + 1;
			if (ok !== 1'b1) begin
				err_total = err_total + 1;
				$display("unexpected at %0t: %0s", $time, msg);
			end
		end
	endtask
	task rd;
		begin
			req = 1'b1;
			@(negedge clk);
			req = 1'b0;
			@(negedge clk);
			while (!done) @(negedge clk);
		end
	endtask
	// End pin held until idle, though only the move into the end point reads it
	task conv(input integer t);
		begin
			cs = 1'b1;
			repeat (4) @(negedge clk);
			cs = 1'b0;
			chk(busy === 1'b1, "busy");
			repeat (t) @(negedge clk);
			ce = 1'b1;
			while (busy) @(negedge clk);
			ce = 1'b0;
			repeat (8) @(negedge clk);
		end
	endtask
	task give_verdict;
		begin
			$display("mismatches %0d, checks %0d", err_total, cmp_count);
			if (err_total == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// Comparator low keeps the DAC at zero, so both points cancel
	task t_zero;
		begin
			conv(300);
			rd;
			chk(word === 20'h0, "zero");
		end
	endtask
	// Rising DAC gives a positive difference; chained ones trail the word
	task t_track;
		begin
			cmp = 1'b1;
			conv(300);
			rd;
			r1 = word;
			chk(dac !== 16'h0, "track");
			chk(r1 !== 20'h0, "diff");
			chk(sdout === 1'b1, "chain1");
		end
	endtask
	// Longer integration collects more steps
	task t_length;
		begin
			conv(600);
			rd;
			chk(word > r1, "length");
		end
	endtask
	// Two oversamples per point roughly double the sum
	task t_count;
		begin
			osn = 8'h02;
			conv(300);
			rd;
			r2 = word;
			chk(r2 > r1, "count");
		end
	endtask
	// Read during a conversion returns the previous whole result
	task t_hold;
		begin
			sdi = 1'b0;
			fork
				conv(400);
				begin
					repeat (20) @(negedge clk);
					rd;
				end
			join
			chk(word === r2, "hold");
			chk(sdout === 1'b0 && oe_n === 1'b0, "chain");
		end
	endtask
	// Test source follows its pin
	task t_test;
		begin
			chk(tsrc === 1'b0, "test off");
			ten = 1'b1;
			repeat (5) @(negedge clk);
			chk(tsrc === 1'b1, "test");
		end
	endtask
	// Main sequence; DAC stays at zero until the comparator goes high
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_zero;
		t_track;
		t_length;
		t_count;
		t_hold;
		t_test;
		give_verdict;
	end
endmodule // tb
